// *** core/kpe_defines.vh ***
// Shared constants for the keypad program editor
`ifndef KPE_DEFINES_VH
`define KPE_DEFINES_VH

// Key codes presented on the keypad code pins
`define KPE_KEY_CANCEL 5'h0a
`define KPE_KEY_SHIFT 5'h0b
`define KPE_KEY_FORWARD 5'h0c
`define KPE_KEY_BACKWARD 5'h0d
`define KPE_KEY_ADD_STEP 5'h0e
`define KPE_KEY_REMOVE 5'h0f
`define KPE_KEY_FORCE_ON 5'h10
`define KPE_KEY_FORCE_OFF 5'h11
`define KPE_KEY_COMMIT 5'h12
`define KPE_KEY_DIGIT_LIM 5'h0a
`define KPE_FUNC_TAG 2'h3

// Display kinds
`define KPE_DK_ADDR 4'h0
`define KPE_DK_CONTENT 4'h1
`define KPE_DK_CLR_PEND 4'h2
`define KPE_DK_INS_PEND 4'h3
`define KPE_DK_IO_MON 4'h4
`define KPE_DK_TIMER 4'h5
`define KPE_DK_COUNTER 4'h6
`define KPE_DK_ERROR 4'h7
`define KPE_DK_BUSY 4'h8

// Clear-all digit sequence and error code
`define KPE_CLR_CODE 12'h348
`define KPE_ERR_UNUSED 8'h01

// Timer and counter references
`define KPE_TC_HUNDREDS 4'h6
`define KPE_TC_LAST 5'h18
`define KPE_TC_RSV_LO 5'h14
`define KPE_TC_RSV_HI 5'h17
`define KPE_TC_COUNT 25
`define KPE_TC_MAX_VAL 14'h270f

// The single valid 16-point pairing: groups 03x and 13x
`define KPE_GRP_PAIR_LO 6'h03
`define KPE_GRP_PAIR_HI 6'h0b

`endif

// *** core/kpe_prog_mem.v ***
// User program memory with registered read data
`timescale 1ns/10ps
module kpe_prog_mem #(
  parameter WORDS = 700,
  parameter AW = 10,
  parameter DW = 16
) (
  // Clock
  input wire clk,
  // Write port
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  // Read port
  input wire [AW-1:0] rd_addr,
  output reg [DW-1:0] rd_data_q
);

  reg [DW-1:0] mem [0:WORDS-1];

  always @(posedge clk)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
    rd_data_q <= mem[rd_addr];
  end

endmodule // kpe_prog_mem

// *** core/kpe_editor.v ***
// Keystroke command interpreter for the programmer keypad
// Notes on behaviour
// - Forward while clear pending erases all memory
// - Cancel while pending abandons clear, memory unchanged
// - Insert only in program mode, before displayed
// - After add step show 'i', await confirm
// - Forward confirms insert, then shows next address
// - Monitor shows selected group plus next group
// - Shift persists; shared key selects monitor, run
// - Four-point selected group keeps upper four indicators off
// - Sixteen-point module shows 030-037 and 130-137
// - Forward/backward step groups, wrap at top and at zero
// - Timer refs 600-624, 620-623 reserved
// - Unused timer/counter reference shows error E01
// - Timer in tenths to 999.9, counter 9999
// - Logic display shows low two reference digits
// - Stepping skips unused timers and counters
// - Shift address forward shows address, then content
// - Shift forward returns display to address zero
// - Force on/off only in run mode
// - Forced state holds exactly one controller scan
`timescale 1ns/10ps
`include "kpe_defines.vh"
module kpe_editor #(
  parameter MEM_WORDS = 700,
  parameter AW = 10,
  parameter IO_GROUPS = 16
) (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Keypad and mode switch pins
  input wire key_strobe,
  input wire [4:0] key_code,
  input wire mode_run,
  input wire mode_prog,
  // Controller I/O image for the selected groups
  input wire [7:0] io_lo_status,
  input wire [7:0] io_hi_status,
  input wire io_pts4,
  input wire io_pts16,
  // Controller timer and counter data for tc_sel_q
  input wire [24:0] tc_used,
  input wire [13:0] tc_value,
  input wire tc_is_timer,
  // Controller scan boundary pulse
  input wire scan_end,
  // Display
  output reg [3:0] disp_kind_q,
  output reg [15:0] disp_val_q,
  output reg [7:0] logic_disp_q,
  output reg [15:0] led_q,
  output reg busy_q,
  // Monitor selections
  output reg [5:0] io_grp_lo_q,
  output reg [5:0] io_grp_hi_q,
  output reg [4:0] tc_sel_q,
  // Force request
  output reg force_act_q,
  output reg force_val_q,
  output reg [8:0] force_ref_q
);

  localparam ST_IDLE = 8'h01;
  localparam ST_CLRPEND = 8'h02;
  localparam ST_CLRRUN = 8'h04;
  localparam ST_INSPEND = 8'h08;
  localparam ST_INSRUN = 8'h10;
  localparam ST_IOMON = 8'h20;
  localparam ST_TCMON = 8'h40;
  localparam ST_TCSEEK = 8'h80;
  localparam [AW-1:0] TOP = MEM_WORDS - 1;
  localparam [5:0] GRP_TOP = IO_GROUPS - 1;

  // Pin synchronisers; stage 3 only feeds the edge detect
  reg ks_s1_q, ks_s2_q, ks_s3_q;
  reg [4:0] kc_s1_q, kc_s2_q;
  reg [1:0] mode_s1_q, mode_s2_q;

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ks_s1_q <= 1'b0;
      ks_s2_q <= 1'b0;
      ks_s3_q <= 1'b0;
      kc_s1_q <= 5'h00;
      kc_s2_q <= 5'h00;
      mode_s1_q <= 2'h0;
      mode_s2_q <= 2'h0;
    end
    else
    begin
      ks_s1_q <= key_strobe;
      ks_s2_q <= ks_s1_q;
      ks_s3_q <= ks_s2_q;
      kc_s1_q <= key_code;
      kc_s2_q <= kc_s1_q;
      mode_s1_q <= {mode_prog, mode_run};
      mode_s2_q <= mode_s1_q;
    end
  end

  wire key_ev = ks_s2_q & ~ks_s3_q;
  wire [4:0] kc = kc_s2_q;
  wire run_m = mode_s2_q[0];
  wire prog_m = mode_s2_q[1];
  wire is_digit = kc < `KPE_KEY_DIGIT_LIM;
  wire is_func = kc[4:3] == `KPE_FUNC_TAG;

  reg [7:0] st_q;
  reg [AW-1:0] cur_addr_q, ptr_q;
  reg show_content_q, shift_q, clr_arm_q, func_q, force_pend_q, force_on_q;
  reg phase_q, force_seen_q, seek_up_q;
  reg [3:0] opcode_q;
  reg [15:0] entry_q, elem_q;
  reg [2:0] ndig_q;
  reg [4:0] seek_cnt_q;
  reg err_q;

  // BCD entry to binary address
  wire [13:0] addr_bin = entry_q[15:12] * 14'd1000 + entry_q[11:8] * 14'd100
    + entry_q[7:4] * 14'd10 + {10'h000, entry_q[3:0]};
  wire addr_ok = addr_bin < MEM_WORDS;
  // Entry as an octal discrete reference
  wire [8:0] oct_ref = {entry_q[10:8], entry_q[6:4], entry_q[2:0]};
  wire oct_ok = ~entry_q[11] & ~entry_q[7] & ~entry_q[3] & (entry_q[15:12] == 4'h0);
  // Entry as a timer or counter index
  wire [6:0] tc_idx7 = entry_q[7:4] * 7'd10 + {3'h0, entry_q[3:0]};
  wire tc_ref = entry_q[11:8] == `KPE_TC_HUNDREDS;

  function tc_valid;
    input [6:0] idx;
    input [24:0] used;
    begin
      tc_valid = (idx <= {2'h0, `KPE_TC_LAST})
        && !(idx >= {2'h0, `KPE_TC_RSV_LO} && idx <= {2'h0, `KPE_TC_RSV_HI})
        && used[idx[4:0]];
    end
  endfunction

  wire [4:0] seek_next = seek_up_q ?
    ((tc_sel_q == `KPE_TC_LAST) ? 5'h00 : tc_sel_q + 5'h01) :
    ((tc_sel_q == 5'h00) ? `KPE_TC_LAST : tc_sel_q - 5'h01);

  // Program memory port steering
  reg mem_we;
  reg [AW-1:0] mem_wa, mem_ra;
  reg [15:0] mem_wd;
  wire [15:0] mem_rd;

  always @*
  begin
    mem_we = 1'b0;
    mem_wa = ptr_q;
    mem_wd = 16'h0000;
    mem_ra = cur_addr_q;
    if (st_q == ST_CLRRUN)
      mem_we = 1'b1;
    if (st_q == ST_INSRUN)
    begin
      mem_ra = ptr_q - {{(AW-1){1'b0}}, 1'b1};
      if (phase_q)
      begin
        mem_we = 1'b1;
        mem_wd = (ptr_q == cur_addr_q) ? elem_q : mem_rd;
      end
    end
  end

  kpe_prog_mem #(
    .WORDS(MEM_WORDS),
    .AW(AW),
    .DW(16)
  ) u_mem (
    .clk(clk),
    .wr_en(mem_we),
    .wr_addr(mem_wa),
    .wr_data(mem_wd),
    .rd_addr(mem_ra),
    .rd_data_q(mem_rd)
  );

  // Keystroke sequencing
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q <= ST_IDLE;
      cur_addr_q <= {AW{1'b0}};
      ptr_q <= {AW{1'b0}};
      show_content_q <= 1'b0;
      shift_q <= 1'b0;
      clr_arm_q <= 1'b0;
      func_q <= 1'b0;
      force_pend_q <= 1'b0;
      force_on_q <= 1'b0;
      phase_q <= 1'b0;
      seek_up_q <= 1'b0;
      seek_cnt_q <= 5'h00;
      opcode_q <= 4'h0;
      entry_q <= 16'h0000;
      elem_q <= 16'h0000;
      ndig_q <= 3'h0;
      err_q <= 1'b0;
      io_grp_lo_q <= 6'h00;
      io_grp_hi_q <= 6'h00;
      tc_sel_q <= 5'h00;
    end
    else
    begin
      // A 16-point module uses 13x as its upper half
      io_grp_hi_q <= (io_grp_lo_q == `KPE_GRP_PAIR_LO && io_pts16) ? `KPE_GRP_PAIR_HI :
        ((io_grp_lo_q == GRP_TOP) ? 6'h00 : io_grp_lo_q + 6'h01);
      case (st_q)
        ST_IDLE:
        begin
          if (key_ev)
          begin
            err_q <= 1'b0;
            if (!(kc == `KPE_KEY_CANCEL || kc == `KPE_KEY_SHIFT || is_digit))
              clr_arm_q <= 1'b0;
            if (is_digit)
            begin
              if (shift_q && ndig_q != 3'h4)
              begin
                entry_q <= {entry_q[11:0], kc[3:0]};
                ndig_q <= ndig_q + 3'h1;
              end
            end
            else if (is_func)
            begin
              func_q <= 1'b1;
              opcode_q <= {1'b0, kc[2:0]};
              shift_q <= 1'b0;
              force_pend_q <= 1'b0;
            end
            else
            begin
              case (kc)
                `KPE_KEY_CANCEL:
                begin
                  clr_arm_q <= 1'b1;
                  show_content_q <= 1'b0;
                  shift_q <= 1'b0;
                  func_q <= 1'b0;
                  force_pend_q <= 1'b0;
                end
                `KPE_KEY_SHIFT:
                begin
                  shift_q <= 1'b1;
                  entry_q <= 16'h0000;
                  ndig_q <= 3'h0;
                end
                `KPE_KEY_FORWARD:
                begin
                  shift_q <= 1'b0;
                  func_q <= 1'b0;
                  if (shift_q && ndig_q == 3'h0)
                  begin
                    cur_addr_q <= {AW{1'b0}};
                    show_content_q <= 1'b0;
                  end
                  else if (shift_q && addr_ok)
                  begin
                    cur_addr_q <= addr_bin[AW-1:0];
                    show_content_q <= 1'b0;
                  end
                  else if (!shift_q && !show_content_q)
                    show_content_q <= 1'b1;
                  else if (!shift_q && cur_addr_q != TOP)
                    cur_addr_q <= cur_addr_q + {{(AW-1){1'b0}}, 1'b1};
                end
                `KPE_KEY_BACKWARD:
                  if (!shift_q && cur_addr_q != {AW{1'b0}})
                  begin
                    cur_addr_q <= cur_addr_q - {{(AW-1){1'b0}}, 1'b1};
                    show_content_q <= 1'b1;
                  end
                `KPE_KEY_REMOVE:
                  if (prog_m && clr_arm_q && shift_q && ndig_q == 3'h3
                      && entry_q[11:0] == `KPE_CLR_CODE)
                  begin
                    st_q <= ST_CLRPEND;
                    shift_q <= 1'b0;
                  end
                `KPE_KEY_ADD_STEP:
                  if (prog_m && func_q && shift_q && ndig_q != 3'h0)
                  begin
                    elem_q <= {opcode_q, entry_q[11:0]};
                    st_q <= ST_INSPEND;
                    shift_q <= 1'b0;
                    func_q <= 1'b0;
                  end
                `KPE_KEY_FORCE_ON:
                  if (!shift_q)
                  begin
                    force_pend_q <= 1'b1;
                    force_on_q <= 1'b1;
                  end
                `KPE_KEY_FORCE_OFF:
                begin
                  if (shift_q && ndig_q != 3'h0 && run_m && !force_pend_q)
                  begin
                    shift_q <= 1'b0;
                    if (tc_ref)
                    begin
                      tc_sel_q <= tc_idx7[4:0];
                      if (tc_valid(tc_idx7, tc_used))
                        st_q <= ST_TCMON;
                      else
                        err_q <= 1'b1;
                    end
                    else if (oct_ok)
                    begin
                      io_grp_lo_q <= (oct_ref[8:3] > GRP_TOP) ? 6'h00 : oct_ref[8:3];
                      st_q <= ST_IOMON;
                    end
                  end
                  else if (!shift_q)
                  begin
                    force_pend_q <= 1'b1;
                    force_on_q <= 1'b0;
                  end
                end
                `KPE_KEY_COMMIT:
                begin
                  force_pend_q <= 1'b0;
                  shift_q <= 1'b0;
                end
                default:
                  shift_q <= shift_q;
              endcase
            end
          end
        end
        ST_CLRPEND:
          if (key_ev && kc == `KPE_KEY_FORWARD)
          begin
            st_q <= ST_CLRRUN;
            ptr_q <= {AW{1'b0}};
          end
          else if (key_ev && kc == `KPE_KEY_CANCEL)
            st_q <= ST_IDLE;
        ST_CLRRUN:
          if (ptr_q == TOP)
          begin
            st_q <= ST_IDLE;
            cur_addr_q <= {AW{1'b0}};
            show_content_q <= 1'b0;
          end
          else
            ptr_q <= ptr_q + {{(AW-1){1'b0}}, 1'b1};
        ST_INSPEND:
          if (key_ev && kc == `KPE_KEY_FORWARD)
          begin
            st_q <= ST_INSRUN;
            ptr_q <= TOP;
            phase_q <= 1'b0;
          end
          else if (key_ev && kc == `KPE_KEY_CANCEL)
            st_q <= ST_IDLE;
        ST_INSRUN:
        begin
          // Two cycles per moved word: read below, then write up; top word falls off
          phase_q <= ~phase_q;
          if (phase_q)
          begin
            if (ptr_q == cur_addr_q)
            begin
              st_q <= ST_IDLE;
              show_content_q <= 1'b0;
              if (cur_addr_q != TOP)
                cur_addr_q <= cur_addr_q + {{(AW-1){1'b0}}, 1'b1};
            end
            else
              ptr_q <= ptr_q - {{(AW-1){1'b0}}, 1'b1};
          end
        end
        ST_IOMON:
          if (key_ev)
          begin
            if (kc == `KPE_KEY_FORWARD)
              io_grp_lo_q <= (io_grp_lo_q == GRP_TOP) ? 6'h00 : io_grp_lo_q + 6'h01;
            else if (kc == `KPE_KEY_BACKWARD)
              io_grp_lo_q <= (io_grp_lo_q == 6'h00) ? GRP_TOP : io_grp_lo_q - 6'h01;
            else if (kc == `KPE_KEY_CANCEL || !run_m)
              st_q <= ST_IDLE;
          end
        ST_TCMON:
          if (key_ev)
          begin
            if (kc == `KPE_KEY_FORWARD || kc == `KPE_KEY_BACKWARD)
            begin
              seek_up_q <= kc == `KPE_KEY_FORWARD;
              seek_cnt_q <= 5'h00;
              st_q <= ST_TCSEEK;
            end
            else if (kc == `KPE_KEY_CANCEL || !run_m)
              st_q <= ST_IDLE;
          end
        ST_TCSEEK:
        begin
          // One step per cycle; a lone used reference simply comes back to itself
          tc_sel_q <= seek_next;
          seek_cnt_q <= seek_cnt_q + 5'h01;
          if (tc_valid({2'h0, seek_next}, tc_used) || seek_cnt_q == `KPE_TC_LAST)
            st_q <= ST_TCMON;
        end
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end

  // Force request, held across one whole scan
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      force_act_q <= 1'b0;
      force_val_q <= 1'b0;
      force_ref_q <= 9'h000;
      force_seen_q <= 1'b0;
    end
    else if (st_q == ST_IDLE && key_ev && kc == `KPE_KEY_COMMIT && force_pend_q
             && shift_q && ndig_q != 3'h0 && oct_ok && run_m)
    begin
      force_act_q <= 1'b1;
      force_val_q <= force_on_q;
      force_ref_q <= oct_ref;
      force_seen_q <= 1'b0;
    end
    else if (force_act_q && scan_end)
    begin
      // First boundary starts the forced scan, the second ends it
      force_seen_q <= 1'b1;
      if (force_seen_q)
        force_act_q <= 1'b0;
    end
  end

  // Display registers
  wire [13:0] tc_clamped = (tc_value > `KPE_TC_MAX_VAL) ? `KPE_TC_MAX_VAL : tc_value;

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      disp_kind_q <= `KPE_DK_ADDR;
      disp_val_q <= 16'h0000;
      logic_disp_q <= 8'h00;
      led_q <= 16'h0000;
      busy_q <= 1'b0;
    end
    else
    begin
      busy_q <= (st_q == ST_CLRRUN) || (st_q == ST_INSRUN) || (st_q == ST_TCSEEK);
      led_q <= 16'h0000;
      logic_disp_q <= 8'h00;
      disp_val_q <= {{(16-AW){1'b0}}, cur_addr_q};
      case (st_q)
        ST_IDLE:
          if (err_q)
          begin
            disp_kind_q <= `KPE_DK_ERROR;
            disp_val_q <= {8'h00, `KPE_ERR_UNUSED};
          end
          else if (show_content_q)
          begin
            disp_kind_q <= `KPE_DK_CONTENT;
            disp_val_q <= mem_rd;
          end
          else
            disp_kind_q <= `KPE_DK_ADDR;
        ST_CLRPEND:
          disp_kind_q <= `KPE_DK_CLR_PEND;
        ST_INSPEND:
          disp_kind_q <= `KPE_DK_INS_PEND;
        ST_IOMON:
        begin
          disp_kind_q <= `KPE_DK_IO_MON;
          disp_val_q <= {10'h000, io_grp_lo_q};
          led_q <= {io_hi_status, io_pts4 ? 4'h0 : io_lo_status[7:4],
            io_lo_status[3:0]};
        end
        ST_TCMON:
        begin
          disp_kind_q <= tc_is_timer ? `KPE_DK_TIMER : `KPE_DK_COUNTER;
          disp_val_q <= {2'h0, tc_clamped};
          logic_disp_q <= {3'h0, tc_sel_q};
        end
        default:
          disp_kind_q <= `KPE_DK_BUSY;
      endcase
    end
  end

endmodule // kpe_editor

// *** test/kpe_chk_properties.sv ***
// Port-level assertions for the keypad program editor
`timescale 1ns/10ps
`include "kpe_defines.vh"
module kpe_chk #(
  parameter IO_GROUPS = 16
) (
  // Clock and reset
  input logic clk,
  input logic reset_n,
  // Controller side
  input logic io_pts4,
  input logic io_pts16,
  input logic [24:0] tc_used,
  input logic [13:0] tc_value,
  input logic scan_end,
  // Display and selections
  input logic [3:0] disp_kind_q,
  input logic [15:0] disp_val_q,
  input logic [15:0] led_q,
  input logic busy_q,
  input logic [5:0] io_grp_lo_q,
  input logic [5:0] io_grp_hi_q,
  input logic [4:0] tc_sel_q,
  input logic force_act_q
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  logic io_m;
  logic tc_m;
  logic [1:0] scan_cnt_q;
  assign io_m = disp_kind_q == `KPE_DK_IO_MON;
  assign tc_m = disp_kind_q == `KPE_DK_TIMER || disp_kind_q == `KPE_DK_COUNTER;
  // Scan boundaries seen while a force stands
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      scan_cnt_q <= 2'h0;
    else if (!force_act_q)
      scan_cnt_q <= 2'h0;
    else if (scan_end)
      scan_cnt_q <= scan_cnt_q + 2'h1;
  end
  sequence s_clear_go;
    disp_kind_q == `KPE_DK_CLR_PEND ##1 busy_q;
  endsequence
  sequence s_clear_done;
    !busy_q && disp_kind_q == `KPE_DK_ADDR && disp_val_q == 16'h0000;
  endsequence
  property p_clear_done;
    s_clear_go |-> ##[1:1000] s_clear_done;
  endproperty
  a_clear_done: assert property (p_clear_done)
    else $error("clear did not end at address zero");
  // Three cycles allow for a pipelined status path
  property p_led_pts4;
    (io_m && io_pts4)[*3] |-> led_q[7:4] == 4'h0;
  endproperty
  a_led_pts4: assert property (p_led_pts4)
    else $error("upper indicators lit on four-point group");
  property p_grp_hi;
    io_m[*2] |-> io_grp_hi_q == (($past(io_pts16) && $past(io_grp_lo_q) == 6'h03) ? 6'h0b :
      ($past(io_grp_lo_q) == IO_GROUPS - 1) ? 6'h00 : $past(io_grp_lo_q) + 6'h01);
  endproperty
  a_grp_hi: assert property (p_grp_hi)
    else $error("upper monitor group wrong");
  property p_force_keep;
    force_act_q && scan_end && scan_cnt_q == 2'h0 |=> force_act_q;
  endproperty
  a_force_keep: assert property (p_force_keep)
    else $error("force dropped before a full scan");
  property p_force_drop;
    force_act_q && scan_end && scan_cnt_q == 2'h1 |=> !force_act_q;
  endproperty
  a_force_drop: assert property (p_force_drop)
    else $error("force held beyond one scan");
  property p_tc_val;
    tc_m && $past(tc_m) && $stable(tc_sel_q) && $past(tc_sel_q, 2) == tc_sel_q
      |-> disp_val_q == (tc_value > 14'h270f ? 16'h270f : {2'h0, tc_value});
  endproperty
  a_tc_val: assert property (p_tc_val)
    else $error("accumulated value shown wrongly");
  property p_tc_ref;
    tc_m && !busy_q |-> tc_used[tc_sel_q] && tc_sel_q <= 5'h18
      && !(tc_sel_q >= 5'h14 && tc_sel_q <= 5'h17);
  endproperty
  a_tc_ref: assert property (p_tc_ref)
    else $error("unused or reserved timer shown");
  property p_err;
    disp_kind_q == `KPE_DK_ERROR |-> disp_val_q == 16'h0001;
  endproperty
  a_err: assert property (p_err)
    else $error("error code wrong");
endmodule // kpe_chk
bind kpe_editor kpe_chk #(.IO_GROUPS(IO_GROUPS)) chk_u (.clk(clk), .reset_n(reset_n),
  .io_pts4(io_pts4), .io_pts16(io_pts16), .tc_used(tc_used), .tc_value(tc_value),
  .scan_end(scan_end), .disp_kind_q(disp_kind_q), .disp_val_q(disp_val_q), .led_q(led_q),
  .busy_q(busy_q), .io_grp_lo_q(io_grp_lo_q), .io_grp_hi_q(io_grp_hi_q),
  .tc_sel_q(tc_sel_q), .force_act_q(force_act_q));

// *** test/kpe_keypad.sv ***
// Operator model pressing keys on the programmer keypad
`timescale 1ns/10ps
module kpe_keypad (
  // Clock
  input logic clk,
  // Key pins
  output logic key_strobe,
  output logic [4:0] key_code
);
  initial
  begin
    key_strobe = 1'b0;
    key_code = 5'h1f;
  end
  // Code settles before the strobe; one cycle after release it is scrambled, not held
  task automatic press(input logic [4:0] code);
    key_code = code;
    repeat (3) @(negedge clk);
    key_strobe = 1'b1;
    repeat (4) @(negedge clk);
    key_strobe = 1'b0;
    @(negedge clk);
    key_code = ~code;
    repeat (6) @(negedge clk);
  endtask
endmodule // kpe_keypad

// *** test/kpe_editor_tb.sv ***
// Self-checking bench for the keypad program editor
`timescale 1ns/10ps
`include "kpe_defines.vh"
module kpe_editor_tb;
  localparam logic [4:0] FWD = `KPE_KEY_FORWARD;
  localparam logic [4:0] CAN = `KPE_KEY_CANCEL;
  localparam logic [4:0] WATCH = `KPE_KEY_FORCE_OFF;
  logic clk;
  logic reset_n;
  logic mode_run;
  logic mode_prog;
  logic scan_end;
  logic [24:0] tc_used;
  logic key_strobe;
  logic [4:0] key_code;
  logic [7:0] io_lo_status;
  logic [7:0] io_hi_status;
  logic io_pts4;
  logic io_pts16;
  logic [13:0] tc_value;
  logic tc_is_timer;
  logic [3:0] disp_kind_q;
  logic [15:0] disp_val_q;
  logic [7:0] logic_disp_q;
  logic [15:0] led_q;
  logic busy_q;
  logic [5:0] io_grp_lo_q;
  logic [5:0] io_grp_hi_q;
  logic [4:0] tc_sel_q;
  logic force_act_q;
  logic force_val_q;
  logic [8:0] force_ref_q;
  logic [15:0] frc_v;
  int fail_count;
  int check_count;
  // Controller image: group 2 is a four-point module, group 3 a sixteen-point one
  assign io_pts4 = io_grp_lo_q == 6'h02;
  assign io_pts16 = io_grp_lo_q == 6'h03;
  assign io_lo_status = 8'h5a ^ {2'h0, io_grp_lo_q};
  assign io_hi_status = 8'h5a ^ {2'h0, io_grp_hi_q};
  assign tc_value = tc_sel_q == 5'h18 ? 14'h3fff : 14'h0064 + {9'h000, tc_sel_q};
  assign tc_is_timer = tc_sel_q < 5'h10;
  assign frc_v = {5'h00, force_act_q, force_val_q, force_ref_q};
  kpe_editor dut_u (.clk(clk), .reset_n(reset_n), .key_strobe(key_strobe),
    .key_code(key_code), .mode_run(mode_run), .mode_prog(mode_prog),
    .io_lo_status(io_lo_status), .io_hi_status(io_hi_status), .io_pts4(io_pts4),
    .io_pts16(io_pts16), .tc_used(tc_used), .tc_value(tc_value), .tc_is_timer(tc_is_timer),
    .scan_end(scan_end), .disp_kind_q(disp_kind_q), .disp_val_q(disp_val_q),
    .logic_disp_q(logic_disp_q), .led_q(led_q), .busy_q(busy_q), .io_grp_lo_q(io_grp_lo_q),
    .io_grp_hi_q(io_grp_hi_q), .tc_sel_q(tc_sel_q), .force_act_q(force_act_q),
    .force_val_q(force_val_q), .force_ref_q(force_ref_q));
  kpe_keypad kp_u (.clk(clk), .key_strobe(key_strobe), .key_code(key_code));
  task automatic tally_and_finish;
    if (fail_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_kind(input logic [3:0] kd);
    chk({12'h000, disp_kind_q}, {12'h000, kd});
  endtask
  task automatic chk_disp(input logic [3:0] kd, input logic [15:0] v);
    chk_kind(kd);
    chk(disp_val_q, v);
  endtask
  task automatic k(input logic [4:0] c);
    kp_u.press(c);
  endtask
  task automatic num(input logic [11:0] d, input int n);
    k(`KPE_KEY_SHIFT);
    for (int i = n - 1; i >= 0; i--)
      k({1'b0, d[4 * i +: 4]});
  endtask
  task automatic mode(input logic r, input logic p);
    mode_run = r;
    mode_prog = p;
    repeat (4) @(negedge clk);
  endtask
  task automatic settle;
    for (int i = 0; i < 3000 && busy_q !== 1'b0; i++)
      @(negedge clk);
    // A busy flag still up here means the operation hung: count it
    chk({15'h0000, busy_q}, 16'h0000);
    repeat (4) @(negedge clk);
  endtask
  task automatic scan;
    scan_end = 1'b1;
    @(negedge clk);
    scan_end = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  task automatic show0;
    num(12'h000, 1);
    k(FWD);
    k(FWD);
  endtask
  task automatic arm;
    k(CAN);
    num(12'h348, 3);
    k(`KPE_KEY_REMOVE);
  endtask
  task automatic t_goto;
    mode(1'b1, 1'b0);
    chk_disp(`KPE_DK_ADDR, 16'h0000);
    num(12'h036, 2);
    k(FWD);
    chk_disp(`KPE_DK_ADDR, 16'h0024);
    k(FWD);
    chk_kind(`KPE_DK_CONTENT);
    k(`KPE_KEY_SHIFT);
    k(FWD);
    chk_disp(`KPE_DK_ADDR, 16'h0000);
  endtask
  task automatic t_insert;
    k(5'h19);
    num(12'h104, 3);
    k(`KPE_KEY_ADD_STEP);
    chk_kind(`KPE_DK_ADDR);
    k(CAN);
    mode(1'b0, 1'b1);
    k(5'h19);
    num(12'h104, 3);
    k(`KPE_KEY_ADD_STEP);
    chk_kind(`KPE_DK_INS_PEND);
    k(FWD);
    settle;
    chk_disp(`KPE_DK_ADDR, 16'h0001);
    show0;
    chk_disp(`KPE_DK_CONTENT, 16'h1104);
  endtask
  task automatic t_clear;
    arm;
    chk_kind(`KPE_DK_CLR_PEND);
    k(CAN);
    show0;
    chk_disp(`KPE_DK_CONTENT, 16'h1104);
    arm;
    k(FWD);
    settle;
    chk_disp(`KPE_DK_ADDR, 16'h0000);
    k(FWD);
    chk_disp(`KPE_DK_CONTENT, 16'h0000);
  endtask
  task automatic t_io;
    k(CAN);
    num(12'h020, 2);
    k(WATCH);
    chk_kind(`KPE_DK_ADDR);
    k(CAN);
    mode(1'b1, 1'b0);
    num(12'h020, 2);
    k(WATCH);
    chk_disp(`KPE_DK_IO_MON, 16'h0002);
    chk(led_q, 16'h5908);
    k(FWD);
    chk(led_q, 16'h5159);
    k(`KPE_KEY_BACKWARD);
    chk({10'h000, io_grp_lo_q}, 16'h0002);
    k(CAN);
    num(12'h170, 3);
    k(WATCH);
    k(FWD);
    chk({10'h000, io_grp_lo_q}, 16'h0000);
    k(CAN);
  endtask
  task automatic bad_ref(input logic [11:0] r);
    num(r, 3);
    k(WATCH);
    chk_disp(`KPE_DK_ERROR, 16'h0001);
    k(CAN);
  endtask
  task automatic t_tc;
    num(12'h601, 3);
    k(WATCH);
    chk_disp(`KPE_DK_TIMER, 16'h0065);
    chk({8'h00, logic_disp_q}, 16'h0001);
    k(FWD);
    settle;
    chk_disp(`KPE_DK_TIMER, 16'h0069);
    chk({8'h00, logic_disp_q}, 16'h0005);
    k(FWD);
    settle;
    chk_disp(`KPE_DK_COUNTER, 16'h270f);
    k(FWD);
    settle;
    chk_disp(`KPE_DK_TIMER, 16'h0065);
    k(`KPE_KEY_BACKWARD);
    settle;
    chk_disp(`KPE_DK_COUNTER, 16'h270f);
    k(CAN);
    bad_ref(12'h602);
    // Reserved reference marked used: it must still be refused
    tc_used[21] = 1'b1;
    bad_ref(12'h621);
  endtask
  task automatic frc(input logic [4:0] key, input logic [15:0] exp);
    k(key);
    num(12'h105, 3);
    k(`KPE_KEY_COMMIT);
    chk(frc_v, exp);
    scan;
    chk(frc_v, exp);
    scan;
    chk({15'h0000, force_act_q}, 16'h0000);
  endtask
  task automatic t_frc_prog;
    mode(1'b0, 1'b1);
    k(`KPE_KEY_FORCE_ON);
    num(12'h105, 3);
    k(`KPE_KEY_COMMIT);
    chk({15'h0000, force_act_q}, 16'h0000);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    reset_n = 1'b0;
    mode_run = 1'b0;
    mode_prog = 1'b0;
    scan_end = 1'b0;
    tc_used = 25'h1000022;
    fail_count = 0;
    check_count = 0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    t_goto;
    t_insert;
    t_clear;
    t_io;
    t_tc;
    frc(`KPE_KEY_FORCE_ON, 16'h0645);
    frc(WATCH, 16'h0445);
    t_frc_prog;
    tally_and_finish;
  end
  // Whole run is under ten thousand cycles; this leaves ample margin
  initial
  begin
    repeat (40000) @(posedge clk);
    fail_count++;
    tally_and_finish;
  end
endmodule // kpe_editor_tb
